// *** src/mpt_timer.sv ***
`timescale 1ns/1ps
`default_nettype none

module mpt_timer
(
    // clock and reset
    input wire logic CLOCK,
    input wire logic SYS_RST,
    // timer pins
    input wire logic INPUT_PIN_A,
    input wire logic INPUT_PIN_B,
    output var logic PWM_OUT,
    output var logic TIMER_IRQ,
    // axi4-lite write
    input wire logic [mpt_pkg::AXI_ADDR_W-1:0] S_AXI_AWADDR,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    input wire logic [mpt_pkg::AXI_DATA_W-1:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    output var logic [1:0] S_AXI_BRESP,
    output var logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    // axi4-lite read
    input wire logic [mpt_pkg::AXI_ADDR_W-1:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    output var logic [mpt_pkg::AXI_DATA_W-1:0] S_AXI_RDATA,
    output var logic [1:0] S_AXI_RRESP,
    output var logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY
);
    import mpt_pkg::*;

    default clocking cb @(posedge CLOCK);
    endclocking
    default disable iff (SYS_RST);

    // ****************************************
    // bus slave
    // ****************************************
    logic aw_got_q, w_got_q;
    logic [AXI_ADDR_W-1:0] aw_addr_q;
    logic [7:0] w_data_q;
    logic w_lane_q;
    logic wr_go, rd_go, wr_hit, rd_hit;
    logic [AXI_DATA_W-1:0] rd_mux;

    assign S_AXI_AWREADY = ~aw_got_q & ~S_AXI_BVALID;
    assign S_AXI_WREADY = ~w_got_q & ~S_AXI_BVALID;
    assign S_AXI_ARREADY = ~S_AXI_RVALID;
    assign wr_go = aw_got_q & w_got_q & ~S_AXI_BVALID;
    assign rd_go = S_AXI_ARVALID & S_AXI_ARREADY;

    always_ff @(posedge CLOCK)
    begin
        if (SYS_RST || wr_go)
        begin
            aw_got_q <= 1'b0;
            w_got_q <= 1'b0;
        end
        else
        begin
            if (S_AXI_AWVALID && S_AXI_AWREADY)
            begin
                aw_got_q <= 1'b1;
                aw_addr_q <= S_AXI_AWADDR;
            end
            if (S_AXI_WVALID && S_AXI_WREADY)
            begin
                w_got_q <= 1'b1;
                w_data_q <= S_AXI_WDATA[7:0];
                w_lane_q <= S_AXI_WSTRB[0];
            end
        end
    end

    always_comb
    begin
        unique case (aw_addr_q)
            OFF_CTRL0, OFF_CTRL1, OFF_CNT_H, OFF_CNT_L, OFF_PER_H, OFF_PER_L,
            OFF_CMP_H, OFF_CMP_L, OFF_FLAGS, OFF_PINSEL, OFF_PULSE: wr_hit = 1'b1;
            default: wr_hit = 1'b0;
        endcase
    end

    always_ff @(posedge CLOCK)
    begin
        if (SYS_RST)
        begin
            S_AXI_BVALID <= 1'b0;
            S_AXI_BRESP <= RESP_OKAY;
        end
        else if (wr_go)
        begin
            S_AXI_BVALID <= 1'b1;
            S_AXI_BRESP <= wr_hit ? RESP_OKAY : RESP_SLVERR;
        end
        else if (S_AXI_BREADY)
            S_AXI_BVALID <= 1'b0;
    end

    // one-cycle write strobes per register; lane 0 carries the byte
    logic wr_cr0, wr_cr1, wr_cnth, wr_cntl, wr_perh, wr_perl, wr_cmph, wr_cmpl, wr_flg, wr_psel;
    assign wr_cr0 = wr_go & w_lane_q & (aw_addr_q == OFF_CTRL0);
    assign wr_cr1 = wr_go & w_lane_q & (aw_addr_q == OFF_CTRL1);
    assign wr_cnth = wr_go & w_lane_q & (aw_addr_q == OFF_CNT_H);
    assign wr_cntl = wr_go & w_lane_q & (aw_addr_q == OFF_CNT_L);
    assign wr_perh = wr_go & w_lane_q & (aw_addr_q == OFF_PER_H);
    assign wr_perl = wr_go & w_lane_q & (aw_addr_q == OFF_PER_L);
    assign wr_cmph = wr_go & w_lane_q & (aw_addr_q == OFF_CMP_H);
    assign wr_cmpl = wr_go & w_lane_q & (aw_addr_q == OFF_CMP_L);
    assign wr_flg = wr_go & w_lane_q & (aw_addr_q == OFF_FLAGS);
    assign wr_psel = wr_go & w_lane_q & (aw_addr_q == OFF_PINSEL);

    // ****************************************
    // control registers
    // ****************************************
    logic [7:0] ctrl0_q, ctrl1_q;
    logic src_sel_q;

    always_ff @(posedge CLOCK)
    begin
        if (SYS_RST)
        begin
            ctrl0_q <= RST_CTRL;
            ctrl1_q <= RST_CTRL;
            src_sel_q <= 1'b0;
        end
        else
        begin
            if (wr_cr0)
                ctrl0_q <= w_data_q;
            if (wr_cr1)
                ctrl1_q <= w_data_q;
            if (wr_psel)
                src_sel_q <= w_data_q[PSEL_SRC_BIT];
        end
    end

    logic [2:0] psc;
    logic [1:0] mode;
    logic pol, edge_sel, run;
    logic is_out, is_cap, is_ctr;
    assign psc = ctrl0_q[CR0_PSC_LSB +: 3];
    assign pol = ctrl0_q[CR0_POL_BIT];
    assign edge_sel = ctrl0_q[CR0_EDGE_BIT];
    assign mode = ctrl0_q[CR0_MODE_LSB +: 2];
    assign run = ctrl1_q[CR1_RUN_BIT];
    assign is_cap = (mode == MODE_CAPTURE);
    assign is_out = (mode == MODE_OUTPUT);
    assign is_ctr = (mode == MODE_COUNTER);

    // ****************************************
    // prescaler and input path
    // ****************************************
    logic [PSC_W-1:0] div_q;
    logic [7:0] psc_span;
    logic tick;

    always_ff @(posedge CLOCK)
    begin
        if (SYS_RST)
            div_q <= '0;
        else
            div_q <= PSC_W'(div_q + 1'b1);
    end

    // no buffering on the select: a mid-count change may give one short period
    assign psc_span = (8'h01 << psc) - 8'h01;
    assign tick = (div_q & psc_span[PSC_W-1:0]) == psc_span[PSC_W-1:0];

    mpt_edge_if eif();
    assign eif.raw = src_sel_q ? INPUT_PIN_B : INPUT_PIN_A;
    assign eif.filt_on = ctrl1_q[CR1_FILT_BIT];

    mpt_in_filter u_filter
    (
        .clk(CLOCK),
        .rst(SYS_RST),
        .eif(eif)
    );

    // ****************************************
    // event decode
    // ****************************************
    logic [15:0] cnt_q, cnt_lat_q, pulse_q;
    logic [15:0] per_pre_q, per_sh_q, cmp_pre_q, cmp_sh_q;
    logic per_pend_q, cmp_pend_q, started_q;
    logic base_step, at_max, start_edge, end_edge, ctd_edge;
    logic o_per_hit, o_cmp_hit, cap_start, cap_width, cap_ovf;
    logic ic_edge, ic_first, ic_hit, ic_ovf;

    assign base_step = run & tick;
    assign at_max = (cnt_q == CNT_MAX);
    assign start_edge = edge_sel ? eif.fall : eif.rise;
    assign end_edge = edge_sel ? eif.rise : eif.fall;
    assign ctd_edge = edge_sel ? eif.rise : eif.fall;

    assign o_per_hit = is_out & base_step & (cnt_q == per_sh_q);
    assign o_cmp_hit = is_out & base_step & (cnt_q == cmp_sh_q);
    assign cap_start = is_cap & run & start_edge;
    assign cap_width = is_cap & run & end_edge & started_q;
    assign cap_ovf = is_cap & base_step & at_max & ~cap_start;
    assign ic_edge = is_ctr & run & ctd_edge;
    assign ic_first = ic_edge & ~started_q;
    assign ic_hit = ic_edge & (16'(pulse_q + 16'h0001) == cmp_sh_q);
    assign ic_ovf = is_ctr & base_step & at_max & ~ic_first & ~ic_hit;

    // ****************************************
    // base count, pulse count
    // ****************************************
    always_ff @(posedge CLOCK)
    begin
        if (SYS_RST)
            cnt_q <= RST_WORD;
        else if (wr_cnth)
            cnt_q[15:8] <= w_data_q;
        else if (wr_cntl)
            cnt_q[7:0] <= w_data_q;
        else if (o_per_hit || cap_start || ic_first || ic_hit || cap_ovf || ic_ovf)
            cnt_q <= RST_WORD;
        else if (base_step)
            cnt_q <= 16'(cnt_q + 16'h0001);
    end

    always_ff @(posedge CLOCK)
    begin
        if (SYS_RST || !run)
            started_q <= 1'b0;
        else if (cap_start || ic_first)
            started_q <= 1'b1;
    end

    always_ff @(posedge CLOCK)
    begin
        if (SYS_RST || !run)
            pulse_q <= RST_WORD;
        else if (ic_hit)
            pulse_q <= RST_WORD;
        else if (ic_edge)
            pulse_q <= 16'(pulse_q + 16'h0001);
    end

    // ****************************************
    // period and compare
    // ****************************************
    logic per_xfer, cmp_xfer;
    assign per_xfer = is_out & (o_per_hit | ~run) & ~per_pend_q;
    assign cmp_xfer = ((is_out & (o_per_hit | ~run)) | (is_ctr & (ic_hit | ic_ovf | ~run))) & ~cmp_pend_q;

    always_ff @(posedge CLOCK)
    begin
        if (SYS_RST)
        begin
            per_pre_q <= RST_WORD;
            per_sh_q <= RST_WORD;
            per_pend_q <= 1'b0;
        end
        else
        begin
            if (wr_perh)
                per_pend_q <= 1'b1;
            else if (wr_perl)
                per_pend_q <= 1'b0;
            if ((is_cap && run && started_q && cap_start) || ic_hit)
            begin
                per_pre_q <= cnt_q;
                per_sh_q <= cnt_q;
            end
            else if (cap_ovf)
            begin
                per_pre_q <= CNT_MAX;
                per_sh_q <= CNT_MAX;
            end
            else
            begin
                if (wr_perh)
                    per_pre_q[15:8] <= w_data_q;
                if (wr_perl)
                    per_pre_q[7:0] <= w_data_q;
                if (per_xfer)
                    per_sh_q <= per_pre_q;
            end
        end
    end

    always_ff @(posedge CLOCK)
    begin
        if (SYS_RST)
        begin
            cmp_pre_q <= RST_WORD;
            cmp_sh_q <= RST_WORD;
            cmp_pend_q <= 1'b0;
        end
        else
        begin
            if (wr_cmph)
                cmp_pend_q <= 1'b1;
            else if (wr_cmpl)
                cmp_pend_q <= 1'b0;
            if (cap_width)
            begin
                cmp_pre_q <= cnt_q;
                cmp_sh_q <= cnt_q;
            end
            else if (cap_ovf)
            begin
                cmp_pre_q <= {16{eif.level ^ pol}};
                cmp_sh_q <= {16{eif.level ^ pol}};
            end
            else
            begin
                if (wr_cmph)
                    cmp_pre_q[15:8] <= w_data_q;
                if (wr_cmpl)
                    cmp_pre_q[7:0] <= w_data_q;
                if (cmp_xfer)
                    cmp_sh_q <= cmp_pre_q;
            end
        end
    end

    // ****************************************
    // flags, interrupt, output pin
    // ****************************************
    logic [2:0] flags_q, flag_set, flag_en;
    assign flag_set = {o_per_hit | cap_ovf | ic_ovf, (is_cap & run & started_q & cap_start) | ic_hit,
                       o_cmp_hit | cap_width};
    assign flag_en = {ctrl1_q[CR1_OEN_BIT], ctrl1_q[CR1_PEN_BIT], ctrl0_q[CR0_MEN_BIT]};

    // a new event in the clearing cycle survives
    always_ff @(posedge CLOCK)
    begin
        if (SYS_RST)
            flags_q <= 3'h0;
        else
            flags_q <= (flags_q & ~(wr_flg ? w_data_q[2:0] : 3'h0)) | flag_set;
    end

    always_ff @(posedge CLOCK)
    begin
        if (SYS_RST)
            TIMER_IRQ <= 1'b0;
        else
            TIMER_IRQ <= |(flags_q & flag_en);
    end

    always_ff @(posedge CLOCK)
    begin
        if (SYS_RST)
            PWM_OUT <= 1'b0;
        else if (!is_out || cmp_sh_q > per_sh_q)
            PWM_OUT <= pol;
        else
            PWM_OUT <= (cnt_q >= cmp_sh_q) ^ pol;
    end

    // ****************************************
    // read path
    // ****************************************
    always_comb
    begin
        rd_mux = '0;
        rd_hit = 1'b1;
        unique case (S_AXI_ARADDR)
            OFF_CTRL0: rd_mux[7:0] = ctrl0_q;
            OFF_CTRL1: rd_mux[7:0] = ctrl1_q;
            OFF_CNT_H: rd_mux[7:0] = cnt_q[15:8];
            OFF_CNT_L: rd_mux[7:0] = cnt_lat_q[7:0];
            OFF_PER_H: rd_mux[7:0] = per_pre_q[15:8];
            OFF_PER_L: rd_mux[7:0] = per_pre_q[7:0];
            OFF_CMP_H: rd_mux[7:0] = cmp_pre_q[15:8];
            OFF_CMP_L: rd_mux[7:0] = cmp_pre_q[7:0];
            OFF_FLAGS: rd_mux[2:0] = flags_q;
            OFF_PINSEL: rd_mux[PSEL_SRC_BIT] = src_sel_q;
            OFF_PULSE: rd_mux[15:0] = pulse_q;
            default: rd_hit = 1'b0;
        endcase
    end

    always_ff @(posedge CLOCK)
    begin
        if (SYS_RST)
            cnt_lat_q <= RST_WORD;
        else if (rd_go && S_AXI_ARADDR == OFF_CNT_H)
            cnt_lat_q <= cnt_q;
    end

    always_ff @(posedge CLOCK)
    begin
        if (SYS_RST)
        begin
            S_AXI_RVALID <= 1'b0;
            S_AXI_RDATA <= '0;
            S_AXI_RRESP <= RESP_OKAY;
        end
        else if (rd_go)
        begin
            S_AXI_RVALID <= 1'b1;
            S_AXI_RDATA <= rd_mux;
            S_AXI_RRESP <= rd_hit ? RESP_OKAY : RESP_SLVERR;
        end
        else if (S_AXI_RREADY)
            S_AXI_RVALID <= 1'b0;
    end

    // ****************************************
    // checks
    // ****************************************
    AST_PSC_MAX: assert property ((psc == 3'h7 && tick) |-> div_q == 7'h7F)
        else $error("prescaler tick off divide-by-128 phase");
    AST_RUN_HOLD: assert property ((!run && !wr_cnth && !wr_cntl) |=> $stable(cnt_q))
        else $error("base count moved while stopped");
    AST_CNT_LATCH: assert property ((rd_go && S_AXI_ARADDR == OFF_CNT_L) |=> S_AXI_RDATA[7:0] == $past(cnt_lat_q[7:0]))
        else $error("low byte read did not return latched value");
    AST_PEND_BLOCK: assert property ((is_out && per_pend_q && !wr_perl) |=> $stable(per_sh_q))
        else $error("period shadow moved between byte writes");
    AST_PWM_LEVEL: assert property ((is_out && cmp_sh_q <= per_sh_q) |=> PWM_OUT == $past((cnt_q >= cmp_sh_q) ^ pol))
        else $error("output level wrong against compare");
    AST_PWM_STUCK: assert property ((cmp_sh_q > per_sh_q) [*2] |-> PWM_OUT == $past(pol))
        else $error("output not held when compare above period");
    AST_MATCH_SET: assert property (o_cmp_hit |=> flags_q[FLG_MATCH])
        else $error("match flag not set on compare");
    AST_OVF_WRAP: assert property ((o_per_hit && !wr_cnth && !wr_cntl) |=> cnt_q == 16'h0000 && flags_q[FLG_OVF])
        else $error("period hit did not clear count and flag overflow");
    AST_CAP_PERIOD: assert property ((is_cap && run && started_q && cap_start) |=> per_pre_q == $past(cnt_q) && flags_q[FLG_PERIOD])
        else $error("capture period not stored");
    AST_CAP_OVF: assert property (cap_ovf |=> per_pre_q == 16'hFFFF && (cmp_pre_q == 16'h0000 || cmp_pre_q == 16'hFFFF))
        else $error("capture overflow values wrong");
    AST_IC_HIT: assert property ((ic_hit && !wr_cnth && !wr_cntl) |=> pulse_q == 16'h0000 && cnt_q == 16'h0000)
        else $error("target reached without clearing counters");
    AST_IC_OVF: assert property ((ic_ovf && !ic_edge) |=> pulse_q == $past(pulse_q) && flags_q[FLG_OVF])
        else $error("counter overflow disturbed pulse count");
    AST_FLAG_STICKY: assert property ((flags_q[FLG_PERIOD] && !wr_flg) |=> flags_q[FLG_PERIOD])
        else $error("period flag dropped without clear");
endmodule

`default_nettype wire

// *** src/mpt_pkg.sv ***
package mpt_pkg;

    // ****************************************
    // bus geometry
    // ****************************************
    localparam int AXI_ADDR_W = 8;
    localparam int AXI_DATA_W = 32;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ****************************************
    // register offsets (byte addresses)
    // ****************************************
    localparam logic [AXI_ADDR_W-1:0] OFF_CTRL0 = 8'h00;
    localparam logic [AXI_ADDR_W-1:0] OFF_CTRL1 = 8'h04;
    localparam logic [AXI_ADDR_W-1:0] OFF_CNT_H = 8'h08;
    localparam logic [AXI_ADDR_W-1:0] OFF_CNT_L = 8'h0C;
    localparam logic [AXI_ADDR_W-1:0] OFF_PER_H = 8'h10;
    localparam logic [AXI_ADDR_W-1:0] OFF_PER_L = 8'h14;
    localparam logic [AXI_ADDR_W-1:0] OFF_CMP_H = 8'h18;
    localparam logic [AXI_ADDR_W-1:0] OFF_CMP_L = 8'h1C;
    localparam logic [AXI_ADDR_W-1:0] OFF_FLAGS = 8'h20;
    localparam logic [AXI_ADDR_W-1:0] OFF_PINSEL = 8'h24;
    localparam logic [AXI_ADDR_W-1:0] OFF_PULSE = 8'h28;

    // ****************************************
    // field positions
    // ****************************************
    localparam int CR0_PSC_LSB = 5;
    localparam int CR0_POL_BIT = 4;
    localparam int CR0_MEN_BIT = 3;
    localparam int CR0_EDGE_BIT = 2;
    localparam int CR0_MODE_LSB = 0;
    localparam int CR1_PEN_BIT = 4;
    localparam int CR1_OEN_BIT = 3;
    localparam int CR1_FILT_BIT = 2;
    localparam int CR1_RUN_BIT = 0;
    localparam int FLG_MATCH = 0;
    localparam int FLG_PERIOD = 1;
    localparam int FLG_OVF = 2;
    localparam int PSEL_SRC_BIT = 0;

    // ****************************************
    // mode codes, reset values, counts
    // ****************************************
    localparam logic [1:0] MODE_CAPTURE = 2'h0;
    localparam logic [1:0] MODE_OUTPUT = 2'h1;
    localparam logic [1:0] MODE_COUNTER = 2'h2;
    localparam logic [7:0] RST_CTRL = 8'h00;
    localparam logic [15:0] RST_WORD = 16'h0000;
    localparam logic [15:0] CNT_MAX = 16'hFFFF;
    localparam int FILTER_LEN = 4;
    localparam int PSC_W = 7;

endpackage

// *** src/mpt_edge_if.sv ***
`timescale 1ns/1ps
`default_nettype none

interface mpt_edge_if;
    logic raw;
    logic filt_on;
    logic level;
    logic rise;
    logic fall;

    modport filter (input raw, input filt_on, output level, output rise, output fall);
    modport user (output raw, output filt_on, input level, input rise, input fall);
endinterface

`default_nettype wire

// *** src/mpt_in_filter.sv ***
`timescale 1ns/1ps
`default_nettype none

module mpt_in_filter
#(
    parameter int LEN = mpt_pkg::FILTER_LEN
)
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // filtered input and edges
    mpt_edge_if.filter eif
);
    import mpt_pkg::*;

    logic [LEN-2:0] hist_q;
    logic level_q;
    logic prev_q;

    always_ff @(posedge clk)
    begin
        if (rst)
            hist_q <= '0;
        else
            hist_q <= {hist_q[LEN-3:0], eif.raw};
    end

    // level moves only after LEN equal samples, so shorter pulses vanish
    always_ff @(posedge clk)
    begin
        if (rst)
            level_q <= 1'b0;
        else if (!eif.filt_on)
            level_q <= eif.raw;
        else if (&{hist_q, eif.raw})
            level_q <= 1'b1;
        else if (~|{hist_q, eif.raw})
            level_q <= 1'b0;
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            prev_q <= 1'b0;
        else
            prev_q <= level_q;
    end

    assign eif.level = level_q;
    assign eif.rise = level_q & ~prev_q;
    assign eif.fall = ~level_q & prev_q;
endmodule

`default_nettype wire

// *** dv/mpt_pulse_src.sv ***
`timescale 1ns/1ps
`default_nettype none

module mpt_pulse_src
(
    // clock
    input wire logic clk,
    // waveform
    input wire logic en,
    input wire logic [15:0] hi_len,
    input wire logic [15:0] lo_len,
    // pin
    output var logic pin
);
    logic [15:0] cnt_q;

    initial pin = 1'b0;

    // idle pin rests low so the timer sees no stray edges
    always @(posedge clk)
    begin
        if (!en)
        begin
            pin <= 1'b0;
            cnt_q <= 16'h0001;
        end
        else if (cnt_q >= (pin ? hi_len : lo_len))
        begin
            pin <= ~pin;
            cnt_q <= 16'h0001;
        end
        else
            cnt_q <= cnt_q + 16'h0001;
    end
endmodule

`default_nettype wire

// *** dv/tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    import mpt_pkg::*;
    // addr, write, read back, resp
    localparam logic [31:0] REGS [6] = '{{OFF_PINSEL, 8'h01, 8'h01, 8'h00}, {OFF_PER_H, 8'h5A, 8'h5A, 8'h00},
        {OFF_CMP_L, 8'hA5, 8'hA5, 8'h00}, {OFF_CTRL0, 8'hE4, 8'hE4, 8'h00}, {OFF_PULSE, 8'hFF, 8'h00, 8'h00},
        {8'h30, 8'h77, 8'h00, 8'h02}};
    // ctrl0, compare, cycles, high cycles; period 9
    localparam logic [47:0] PWMR [5] = '{{8'h01, 8'h04, 16'h0064, 16'h003C}, {8'h11, 8'h04, 16'h0064, 16'h0028},
        {8'h01, 8'h0B, 16'h0064, 16'h0000}, {8'h11, 8'h0B, 16'h0064, 16'h0064}, {8'h21, 8'h04, 16'h00C8, 16'h0078}};
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic src_en = 1'b0;
    logic pin_a = 1'b0;
    logic pin_b;
    logic [7:0] awaddr = 8'h00;
    logic [7:0] araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, pwm, irq;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    int err_count = 0, n_checks = 0, cyc = 0;

    mpt_timer i_dut (.CLOCK(clk), .SYS_RST(rst), .INPUT_PIN_A(pin_a), .INPUT_PIN_B(pin_b), .PWM_OUT(pwm),
        .TIMER_IRQ(irq), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
        .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
        .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
        .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
        .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready));
    mpt_pulse_src i_src (.clk(clk), .en(src_en), .hi_len(16'h001E), .lo_len(16'h0032), .pin(pin_b));

    always #20 clk = ~clk;

    // ****************************************
    // bus and check tasks
    // ****************************************
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            err_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // leading edge keeps two tasks from driving one signal in a time step
    task wr(input logic [7:0] a, input logic [7:0] d, output logic [1:0] r);
        @(posedge clk);
        awaddr <= a;
        wdata <= {24'h0, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do
        begin
            @(posedge clk);
            if (awready === 1'b1)
                awvalid <= 1'b0;
            if (wready === 1'b1)
                wvalid <= 1'b0;
        end
        while (bvalid !== 1'b1);
        r = bresp;
        bready <= 1'b0;
    endtask

    task w(input logic [7:0] a, input logic [7:0] d);
        logic [1:0] r;
        wr(a, d, r);
    endtask

    task rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do
        begin
            @(posedge clk);
            if (arready === 1'b1)
                arvalid <= 1'b0;
        end
        while (rvalid !== 1'b1);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask

    task rd16(input logic [7:0] a, output logic [15:0] v);
        logic [31:0] d;
        logic [1:0] r;
        rd(a, d, r);
        v[15:8] = d[7:0];
        rd(a + 8'h04, d, r);
        v[7:0] = d[7:0];
    endtask

    task w16(input logic [7:0] a, input logic [15:0] v);
        w(a, v[15:8]);
        w(a + 8'h04, v[7:0]);
    endtask

    task close_out;
        $display("checks %0d errors %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            err_count++;
            close_out;
        end
    end

    // ****************************************
    // main sequence
    // ****************************************
    initial
    begin
        logic [31:0] d;
        logic [1:0] r;
        logic [15:0] per, cmp;
        int h;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        for (int i = 0; i < 6; i++)
        begin
            rd(REGS[i][31:24], d, r);
            chk(d, 32'h0);
            wr(REGS[i][31:24], REGS[i][23:16], r);
            chk(r, REGS[i][1:0]);
            rd(REGS[i][31:24], d, r);
            chk(d, REGS[i][15:8]);
            chk(r, REGS[i][1:0]);
        end
        for (int i = 0; i < 5; i++)
        begin
            w(OFF_CTRL1, 8'h00);
            w(OFF_FLAGS, 8'h07);
            w16(OFF_PER_H, 16'h0009);
            w16(OFF_CMP_H, {8'h00, PWMR[i][39:32]});
            w(OFF_CTRL0, PWMR[i][47:40]);
            w(OFF_CTRL1, 8'h01);
            repeat (40) @(posedge clk);
            h = 0;
            repeat (PWMR[i][31:16])
            begin
                @(posedge clk);
                if (pwm === 1'b1)
                    h++;
            end
            chk(h, PWMR[i][15:0]);
            rd(OFF_FLAGS, d, r);
            chk(d, (PWMR[i][39:32] <= 8'h09) ? 32'h5 : 32'h4);
        end
        w(OFF_CTRL1, 8'h09);
        repeat (2) @(posedge clk);
        chk(irq, 1'b1);
        w(OFF_CTRL1, 8'h01);
        repeat (2) @(posedge clk);
        chk(irq, 1'b0);
        w(OFF_CTRL1, 8'h00);
        w16(OFF_CNT_H, 16'h12FF);
        repeat (10) @(posedge clk);
        rd16(OFF_CNT_H, per);
        chk(per, 16'h12FF);
        w(OFF_CNT_L, 8'h00);
        rd(OFF_CNT_L, d, r);
        chk(d, 32'hFF);
        src_en <= 1'b1;
        for (int e = 0; e < 2; e++)
        begin
            w(OFF_CTRL1, 8'h00);
            w(OFF_FLAGS, 8'h07);
            w(OFF_CTRL0, e ? 8'h04 : 8'h00);
            w(OFF_CTRL1, 8'h05);
            repeat (300) @(posedge clk);
            rd16(OFF_PER_H, per);
            rd16(OFF_CMP_H, cmp);
            chk(per - cmp, e ? 32'h1E : 32'h32);
            chk(per >= 16'h004F && per <= 16'h0051, 1'b1);
            rd(OFF_FLAGS, d, r);
            chk(d & 32'h3, 32'h3);
        end
        w(OFF_CTRL1, 8'h00);
        w(OFF_FLAGS, 8'h07);
        w16(OFF_CMP_H, 16'h0003);
        w(OFF_CTRL0, 8'h06);
        w(OFF_CTRL1, 8'h05);
        // read between the first hit and the second, whatever the input phase
        repeat (300) @(posedge clk);
        rd16(OFF_PER_H, per);
        chk(per >= 16'h009F && per <= 16'h00A1, 1'b1);
        rd(OFF_FLAGS, d, r);
        chk(d & 32'h2, 32'h2);
        // after a hit the pulse count restarts from zero: three fresh edges
        repeat (200) @(posedge clk);
        rd16(OFF_PER_H, per);
        chk(per >= 16'h00EF && per <= 16'h00F1, 1'b1);
        src_en <= 1'b0;
        w(OFF_CTRL1, 8'h00);
        w(OFF_FLAGS, 8'h07);
        w(OFF_CTRL0, 8'h10);
        w16(OFF_CNT_H, 16'hFFF0);
        w(OFF_CTRL1, 8'h01);
        repeat (40) @(posedge clk);
        rd16(OFF_PER_H, per);
        chk(per, 16'hFFFF);
        rd16(OFF_CMP_H, cmp);
        chk(cmp, 16'hFFFF);
        rd(OFF_FLAGS, d, r);
        chk(d & 32'h4, 32'h4);
        w(OFF_CTRL1, 8'h00);
        w(OFF_FLAGS, 8'h07);
        w(OFF_CTRL0, 8'h02);
        w16(OFF_CNT_H, 16'hFFF0);
        w(OFF_CTRL1, 8'h01);
        repeat (40) @(posedge clk);
        rd(OFF_FLAGS, d, r);
        chk(d & 32'h6, 32'h4);
        w(OFF_CTRL1, 8'h00);
        w(OFF_FLAGS, 8'h07);
        w(OFF_PINSEL, 8'h00);
        w(OFF_CTRL0, 8'h00);
        w(OFF_CTRL1, 8'h05);
        // three-cycle pulse must vanish, six-cycle pulse must be captured
        for (int p = 3; p < 7; p += 3)
        begin
            pin_a <= 1'b1;
            repeat (p) @(posedge clk);
            pin_a <= 1'b0;
            repeat (20) @(posedge clk);
            rd(OFF_FLAGS, d, r);
            chk(d, (p > 3) ? 32'h1 : 32'h0);
        end
        rd16(OFF_CMP_H, cmp);
        chk(cmp, 16'h0005);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        rd(OFF_CTRL1, d, r);
        chk(d, 32'h0);
        rd(OFF_FLAGS, d, r);
        chk(d, 32'h0);
        close_out;
    end
endmodule

`default_nettype wire
